// file: rtl/rsr_defs.svh
// Constants of the run, stop and reset control block
// What this block does
// - A trip blocks restart until reset
// - Accepted reset clears trip, message and lamp
// - Warnings clear themselves when condition goes
// - Manual recovery output while manual trip active
// - Level mode: held run starts at reset
// - Autoreset only while reset level held
// - Attempts counted; at maximum stay tripped
// - Retry exhausted output at attempt maximum
// - Autoreset enable and delay per category
// - Undervoltage trip while running: delay starts when fault clears
// - No autoreset under keypad or bus control
// - Reset input rising edge resets a trip
// - Inputs default to edge control
// - Edge mode: fresh run edge after reset
// - Edge mode: run edges only start
// - Edges need enable and stop high; last wins
// - Enable low blocks run, motor coasts
// - Unassigned enable counts as active
// - Stop input low stops the motor
// - Level mode: input active while held high
// - Level mode: both runs active means stop
// - Keypad, input or virtual reset; keypad and input default
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH

`define RSR_CLK_NS       10
`define RSR_CLK_DIV      10
`define RSR_TICK_NS      1000000
`define RSR_TICK_CYCLES  (`RSR_TICK_NS * `RSR_CLK_DIV / `RSR_CLK_NS / `RSR_CLK_DIV * 1)

`define RSR_OFF_CTRL     8'h00
`define RSR_OFF_AR_ENA   8'h04
`define RSR_OFF_AR_MAX   8'h08
`define RSR_OFF_CMD      8'h0c
`define RSR_OFF_STATUS   8'h10
`define RSR_OFF_DLY0     8'h14
`define RSR_LAST_WORD    6'h09
`define RSR_DLY_BASE_IDX 4'h5

`define RSR_CTRL_RESET   8'h1c
`define RSR_AR_ENA_RESET 5'h00
`define RSR_AR_MAX_RESET 4'h0
`define RSR_DLY_RESET    16'h0000

`define RSR_SRC_REMOTE   2'h0
`define RSR_SRC_KEYPAD   2'h1
`define RSR_SRC_BUS      2'h2

`define RSR_CAT_MAINS    4
`define RSR_CMD_RST_BIT  2

`endif

// file: rtl/rsr_pkg.sv
// Types of the run, stop and reset control block
package rsr_pkg;

    typedef enum logic [1:0] {RSR_IDLE, RSR_RUN, RSR_TRIP} rsr_phase_t;

    typedef struct packed {
        logic fwd;
        logic rev;
        logic stop;
        logic enable;
        logic rst;
    } rsr_pins_t;

    typedef struct packed {
        rsr_pins_t s1;
        rsr_pins_t s2;
    } rsr_sync_t;

    typedef struct packed {
        logic [1:0] src;
        logic       rst_vio;
        logic       rst_din;
        logic       rst_key;
        logic       stop_asg;
        logic       ena_asg;
        logic       level;
    } rsr_ctrl_t;

    typedef struct packed {
        logic run;
        logic dir_rev;
        logic coast;
        logic lamp;
        logic msg;
        logic warn;
        logic pend;
        logic exh;
    } rsr_outs_t;

endpackage

// file: rtl/rsr_sync.sv
// Two-stage synchroniser for the control input pins
`timescale 1ns/100ps
`default_nettype none

module rsr_sync (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire rsr_pkg::rsr_pins_t pins_in,
    output      rsr_pkg::rsr_pins_t pins_out
);

    rsr_pkg::rsr_sync_t st_reg;
    rsr_pkg::rsr_sync_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pins_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins_out = st_reg.s2;

endmodule

`default_nettype wire

// file: rtl/rsr_ctrl.sv
// Run, stop and reset qualification with trip recovery and APB registers
`timescale 1ns/100ps
`default_nettype none
`include "rsr_defs.svh"

module rsr_ctrl #(
    parameter int unsigned TICK_CYCLES = `RSR_TICK_CYCLES
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        FORWARD_RUN_INPUT,
    input  wire logic        REVERSE_RUN_INPUT,
    input  wire logic        STOP_INPUT,
    input  wire logic        ENABLE_INPUT,
    input  wire logic        FOURTH_DIGITAL_INPUT,
    input  wire logic        VIO_RESET,
    input  wire logic        KEY_RESET,
    input  wire logic [4:0]  FAULT_IN,
    input  wire logic        WARN_IN,
    output logic             RUN_OUT,
    output logic             DIR_REV_OUT,
    output logic             COAST_OUT,
    output logic             TRIP_LAMP_OUT,
    output logic             ALARM_MSG_OUT,
    output logic             WARN_OUT,
    output logic             MANUAL_RECOVERY_PENDING_OUT,
    output logic             RETRY_EXHAUSTED_OUT
);

    typedef struct packed {
        rsr_pkg::rsr_phase_t  phase;
        rsr_pkg::rsr_pins_t   prev;
        logic                 vio_prev;
        logic [4:0]           cats;
        logic                 run_at_trip;
        logic [3:0]           attempts;
        logic                 dly_on;
        logic [15:0]          dly_cnt;
        logic [16:0]          tick_cnt;
        rsr_pkg::rsr_ctrl_t   ctrl;
        logic [4:0]           ar_ena;
        logic [3:0]           ar_max;
        logic [1:0]           bus_run;
        logic                 bus_rst;
        logic [4:0][15:0]     dly;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
        rsr_pkg::rsr_outs_t   outs;
    } rsr_state_t;

    rsr_state_t         st_reg;
    rsr_state_t         st_next;
    rsr_pkg::rsr_pins_t s;
    rsr_pkg::rsr_pins_t rise;
    logic               enable_ok;
    logic               stop_ok;
    logic               remote;
    logic               man_rst;
    logic               ar_ok;
    logic               cond_clear;
    logic [15:0]        dly_sel;
    logic               acc;
    logic [3:0]         dly_idx;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[1:0] == 2'h0) && (a[7:2] <= `RSR_LAST_WORD);
    endfunction

    // Longest delay of all latched categories wins
    function automatic logic [15:0] max_delay(input logic [4:0] c,
                                              input logic [4:0][15:0] d);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            if (c[i] && d[i] > m) begin
                m = d[i];
            end
        end
        max_delay = m;
    endfunction

    rsr_sync u_sync (
        .clk      (SYS_CLK),
        .rst      (RST),
        .pins_in  ('{fwd: FORWARD_RUN_INPUT, rev: REVERSE_RUN_INPUT, stop: STOP_INPUT,
                     enable: ENABLE_INPUT, rst: FOURTH_DIGITAL_INPUT}),
        .pins_out (s)
    );

    always_comb begin
        rise       = s & ~st_reg.prev;
        enable_ok  = ~st_reg.ctrl.ena_asg | s.enable;
        stop_ok    = ~st_reg.ctrl.stop_asg | s.stop;
        remote     = st_reg.ctrl.src == `RSR_SRC_REMOTE;
        cond_clear = ~|(FAULT_IN & st_reg.cats);
        dly_sel    = max_delay(st_reg.cats, st_reg.dly);
        acc        = PSEL & PENABLE & st_reg.pready;
        dly_idx    = 4'(PADDR[5:2] - `RSR_DLY_BASE_IDX);
        // Any configured reset source; keypad enabled out of reset
        man_rst    = (KEY_RESET & st_reg.ctrl.rst_key)
                   | (rise.rst & st_reg.ctrl.rst_din)
                   | (VIO_RESET & ~st_reg.vio_prev & st_reg.ctrl.rst_vio)
                   | (st_reg.bus_rst & st_reg.ctrl.src == `RSR_SRC_BUS);
        // Autoreset needs remote control, held reset level, all latched categories
        // enabled and attempts left
        ar_ok      = remote
                   & ((st_reg.ctrl.rst_din & s.rst) | (st_reg.ctrl.rst_vio & VIO_RESET))
                   & (&(st_reg.ar_ena | ~st_reg.cats))
                   & (st_reg.attempts < st_reg.ar_max);
    end

    always_comb begin
        st_next          = st_reg;
        st_next.prev     = s;
        st_next.vio_prev = VIO_RESET;
        st_next.bus_rst  = 1'b0;

        // APB slave: one wait state, ready from a flop
        st_next.pready  = PSEL & PENABLE & ~st_reg.pready;
        st_next.pslverr = PSEL & PENABLE & ~st_reg.pready & ~addr_ok(PADDR);
        st_next.prdata  = 32'h00000000;
        if (PSEL && PENABLE && !st_reg.pready && !PWRITE && addr_ok(PADDR)) begin
            case (PADDR)
                `RSR_OFF_CTRL:   st_next.prdata = {24'h000000, st_reg.ctrl};
                `RSR_OFF_AR_ENA: st_next.prdata = {27'h0000000, st_reg.ar_ena};
                `RSR_OFF_AR_MAX: st_next.prdata = {28'h0000000, st_reg.ar_max};
                `RSR_OFF_CMD:    st_next.prdata = {30'h00000000, st_reg.bus_run};
                `RSR_OFF_STATUS: st_next.prdata = {17'h00000, st_reg.attempts,
                                                   st_reg.cats, st_reg.phase,
                                                   st_reg.outs.exh, st_reg.outs.pend,
                                                   st_reg.outs.warn, st_reg.outs.dir_rev};
                default:         st_next.prdata = {16'h0000, st_reg.dly[dly_idx[2:0]]};
            endcase
        end
        if (acc && PWRITE && addr_ok(PADDR)) begin
            case (PADDR)
                `RSR_OFF_CTRL:   st_next.ctrl    = PWDATA[7:0];
                `RSR_OFF_AR_ENA: st_next.ar_ena  = PWDATA[4:0];
                `RSR_OFF_AR_MAX: st_next.ar_max  = PWDATA[3:0];
                `RSR_OFF_CMD: begin
                    st_next.bus_run = PWDATA[1:0];
                    st_next.bus_rst = PWDATA[`RSR_CMD_RST_BIT];
                end
                `RSR_OFF_STATUS: st_next.ctrl    = st_reg.ctrl;
                default:         st_next.dly[dly_idx[2:0]] = PWDATA[15:0];
            endcase
        end

        case (st_reg.phase)
            rsr_pkg::RSR_TRIP: begin
                st_next.cats = st_reg.cats | FAULT_IN;
                if (man_rst) begin
                    // Leave trip; run needs a new qualification next cycle
                    st_next.phase    = rsr_pkg::RSR_IDLE;
                    st_next.cats     = 5'h00;
                    st_next.attempts = 4'h0;
                    st_next.dly_on   = 1'b0;
                end else if (!ar_ok) begin
                    st_next.dly_on   = 1'b0;
                    st_next.dly_cnt  = 16'h0000;
                    st_next.tick_cnt = 17'h00000;
                end else if (!st_reg.dly_on) begin
                    // Undervoltage while running waits for the fault to go
                    if (cond_clear || !(st_reg.cats[`RSR_CAT_MAINS] && st_reg.run_at_trip)) begin
                        st_next.dly_on = 1'b1;
                    end
                end else if (st_reg.dly_cnt >= dly_sel && cond_clear) begin
                    st_next.phase    = rsr_pkg::RSR_IDLE;
                    st_next.cats     = 5'h00;
                    st_next.attempts = 4'(st_reg.attempts + 4'h1);
                    st_next.dly_on   = 1'b0;
                end else if (st_reg.tick_cnt == 17'(TICK_CYCLES - 1)) begin
                    st_next.tick_cnt = 17'h00000;
                    if (st_reg.dly_cnt != 16'hffff) begin
                        st_next.dly_cnt = 16'(st_reg.dly_cnt + 16'h0001);
                    end
                end else begin
                    st_next.tick_cnt = 17'(st_reg.tick_cnt + 17'h00001);
                end
            end
            rsr_pkg::RSR_IDLE, rsr_pkg::RSR_RUN: begin
                if (|FAULT_IN) begin
                    st_next.phase       = rsr_pkg::RSR_TRIP;
                    st_next.cats        = FAULT_IN;
                    st_next.run_at_trip = st_reg.phase == rsr_pkg::RSR_RUN;
                    st_next.dly_on      = 1'b0;
                    st_next.dly_cnt     = 16'h0000;
                    st_next.tick_cnt    = 17'h00000;
                end else if (!enable_ok || !stop_ok) begin
                    st_next.phase = rsr_pkg::RSR_IDLE;
                end else if (!remote) begin
                    // Keypad or bus run levels, both means stop
                    st_next.phase   = (^st_reg.bus_run) ? rsr_pkg::RSR_RUN : rsr_pkg::RSR_IDLE;
                    st_next.outs.dir_rev = st_reg.bus_run[1];
                end else if (st_reg.ctrl.level) begin
                    st_next.phase   = (s.fwd ^ s.rev) ? rsr_pkg::RSR_RUN
                                                     : rsr_pkg::RSR_IDLE;
                    st_next.outs.dir_rev = s.rev;
                end else if (rise.rev) begin
                    // Edges only start; the newest edge sets direction
                    st_next.phase   = rsr_pkg::RSR_RUN;
                    st_next.outs.dir_rev = 1'b1;
                end else if (rise.fwd) begin
                    st_next.phase   = rsr_pkg::RSR_RUN;
                    st_next.outs.dir_rev = 1'b0;
                end
            end
            default: st_next.phase = rsr_pkg::RSR_IDLE;
        endcase
        if (st_next.phase != rsr_pkg::RSR_TRIP) begin
            st_next.dly_cnt  = 16'h0000;
            st_next.tick_cnt = 17'h00000;
        end

        st_next.outs.run     = st_next.phase == rsr_pkg::RSR_RUN;
        st_next.outs.coast   = ~enable_ok;
        st_next.outs.lamp    = st_next.phase == rsr_pkg::RSR_TRIP;
        st_next.outs.msg     = st_next.phase == rsr_pkg::RSR_TRIP;
        st_next.outs.warn    = WARN_IN;
        st_next.outs.pend    = st_reg.phase == rsr_pkg::RSR_TRIP && !man_rst && !ar_ok;
        st_next.outs.exh     = st_reg.ar_max != 4'h0 && st_next.attempts >= st_reg.ar_max;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            st_reg        <= '0;
            st_reg.ctrl   <= `RSR_CTRL_RESET;
            st_reg.ar_ena <= `RSR_AR_ENA_RESET;
            st_reg.ar_max <= `RSR_AR_MAX_RESET;
            st_reg.dly    <= {5{`RSR_DLY_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA                      = st_reg.prdata;
    assign PREADY                      = st_reg.pready;
    assign PSLVERR                     = st_reg.pslverr;
    assign RUN_OUT                     = st_reg.outs.run;
    assign DIR_REV_OUT                 = st_reg.outs.dir_rev;
    assign COAST_OUT                   = st_reg.outs.coast;
    assign TRIP_LAMP_OUT               = st_reg.outs.lamp;
    assign ALARM_MSG_OUT               = st_reg.outs.msg;
    assign WARN_OUT                    = st_reg.outs.warn;
    assign MANUAL_RECOVERY_PENDING_OUT = st_reg.outs.pend;
    assign RETRY_EXHAUSTED_OUT         = st_reg.outs.exh;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_trip_no_run: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP |-> !RUN_OUT)
        else $error("run active while tripped");
    a_reset_clears_lamp: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP && man_rst && FAULT_IN == 5'h00
        |=> !TRIP_LAMP_OUT && !ALARM_MSG_OUT)
        else $error("reset left lamp or message on");
    a_warn_clears: assert property (
        $fell(WARN_IN) |=> !WARN_OUT)
        else $error("warning held after condition went");
    a_pending_shown: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP && !man_rst && !ar_ok
        |=> MANUAL_RECOVERY_PENDING_OUT)
        else $error("manual recovery pending not shown");
    a_level_restart: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP && man_rst && FAULT_IN == 5'h00
        && remote && st_reg.ctrl.level
        ##1 s.fwd && !s.rev && enable_ok && stop_ok && FAULT_IN == 5'h00 |=> RUN_OUT)
        else $error("level mode did not start after reset");
    a_exhausted_holds: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP && st_reg.attempts >= st_reg.ar_max && !man_rst
        |=> st_reg.phase == rsr_pkg::RSR_TRIP)
        else $error("autoreset beyond allowed attempts");
    a_no_bus_autoreset: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP && !remote && !man_rst
        |=> st_reg.phase == rsr_pkg::RSR_TRIP)
        else $error("autoreset under keypad or bus control");
    a_edge_fresh: assert property (
        st_reg.phase == rsr_pkg::RSR_TRIP ##1 st_reg.phase == rsr_pkg::RSR_IDLE
        && remote && !st_reg.ctrl.level && !rise.fwd && !rise.rev |=> !RUN_OUT)
        else $error("edge mode restarted without new edge");
    a_enable_coast: assert property (
        !enable_ok |=> !RUN_OUT && COAST_OUT)
        else $error("enable low did not block run");
    a_stop_low: assert property (
        !stop_ok |=> !RUN_OUT)
        else $error("stop low did not stop");
    a_both_stop: assert property (
        remote && st_reg.ctrl.level && s.fwd && s.rev |=> !RUN_OUT)
        else $error("both run inputs did not stop");

    c_edge_start: cover property (
        !RUN_OUT ##1 RUN_OUT && !st_reg.ctrl.level);
    c_auto_reset: cover property (
        st_reg.phase == rsr_pkg::RSR_TRIP && !man_rst ##1 st_reg.phase == rsr_pkg::RSR_IDLE);
    c_exhausted: cover property ($rose(RETRY_EXHAUSTED_OUT));

endmodule

`default_nettype wire

// file: dv/rsr_pins_model.sv
// Model of the switches or controller driving the control pins
`timescale 1ns/100ps
`default_nettype none

module rsr_pins_model (
    input  wire logic clk,
    output logic      fwd,
    output logic      rev,
    output logic      stop,
    output logic      enable,
    output logic      rst_pin
);
    initial begin
        {fwd, rev, stop, enable, rst_pin} = 5'h00;
    end

    // Levels change just after an edge, like a controller output scan
    task automatic set_pins(input logic [4:0] v);
        @(posedge clk);
        {fwd, rev, stop, enable, rst_pin} <= v;
    endtask

    // Fresh low-high transition; the other run pin is left alone
    task automatic run_edge(input logic reverse);
        @(posedge clk);
        if (reverse) rev <= 1'b0; else fwd <= 1'b0;
        repeat (4) @(posedge clk);
        if (reverse) rev <= 1'b1; else fwd <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // Rising edge on reset pin, optionally kept high for autoreset
    task automatic reset_edge(input logic hold);
        @(posedge clk);
        rst_pin <= 1'b0;
        repeat (4) @(posedge clk);
        rst_pin <= 1'b1;
        repeat (4) @(posedge clk);
        if (!hold) rst_pin <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: dv/test_run_stop_reset_control.sv
// Self-checking bench of the run, stop and reset control block
`timescale 1ns/100ps
`default_nettype none
`include "rsr_defs.svh"

module test_run_stop_reset_control;
    localparam int O_RUN = 0, O_DIR = 1, O_COAST = 2, O_LAMP = 3;
    localparam int O_MSG = 4, O_WARN = 5, O_PEND = 6, O_EXH = 7;
    logic        SYS_CLK;
    logic        RST;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] rdata, v;
    logic        rerr;
    logic        VIO_RESET;
    logic        KEY_RESET;
    logic        WARN_IN;
    logic [4:0]  FAULT_IN;
    wire  [31:0] prdata_w;
    wire         pready_w;
    wire         pslverr_w;
    wire         fwd_w;
    wire         rev_w;
    wire         stop_w;
    wire         ena_w;
    wire         rpin_w;
    wire  [7:0]  outs;
    integer      seed, fail_count, checks_done;

    rsr_pins_model pins (
        .clk(SYS_CLK),
        .fwd(fwd_w),
        .rev(rev_w),
        .stop(stop_w),
        .enable(ena_w),
        .rst_pin(rpin_w)
    );
    rsr_ctrl #(.TICK_CYCLES(4)) dut (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(prdata_w),
        .PREADY(pready_w),
        .PSLVERR(pslverr_w),
        .FORWARD_RUN_INPUT(fwd_w),
        .REVERSE_RUN_INPUT(rev_w),
        .STOP_INPUT(stop_w),
        .ENABLE_INPUT(ena_w),
        .FOURTH_DIGITAL_INPUT(rpin_w),
        .VIO_RESET(VIO_RESET),
        .KEY_RESET(KEY_RESET),
        .FAULT_IN(FAULT_IN),
        .WARN_IN(WARN_IN),
        .RUN_OUT(outs[0]),
        .DIR_REV_OUT(outs[1]),
        .COAST_OUT(outs[2]),
        .TRIP_LAMP_OUT(outs[3]),
        .ALARM_MSG_OUT(outs[4]),
        .WARN_OUT(outs[5]),
        .MANUAL_RECOVERY_PENDING_OUT(outs[6]),
        .RETRY_EXHAUSTED_OUT(outs[7])
    );

    function automatic logic [31:0] exp_ctrl(input logic [1:0] src, input logic [5:0] f);
        return {24'h0, src, f};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (pready_w !== 1'b1 && n < 20);
        rdata = prdata_w;
        rerr = pslverr_w;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, rdata, exp);
    endtask

    // Polls a settled output; bound keeps a dead output from hanging
    task automatic wait_out(input int idx, input logic exp, input int lim, input string what);
        int n;
        n = 0;
        while (outs[idx] !== exp && n < lim) begin
            @(posedge SYS_CLK);
            n++;
        end
        chk(what, {31'h0, outs[idx]}, {31'h0, exp});
    endtask

    task automatic fault(input logic [4:0] f);
        @(posedge SYS_CLK);
        FAULT_IN <= f;
        @(posedge SYS_CLK);
        FAULT_IN <= 5'h00;
    endtask

    task automatic key_pulse();
        @(posedge SYS_CLK);
        KEY_RESET <= 1'b1;
        @(posedge SYS_CLK);
        KEY_RESET <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    initial begin
        #300000;
        fail_count++;
        final_report();
    end

    initial begin
        {PSEL, PENABLE, PWRITE, VIO_RESET, KEY_RESET, WARN_IN} = 6'h00;
        {PADDR, PWDATA, FAULT_IN} = '0;
        seed = 32'hf4c67ae5;
        fail_count = 0;
        checks_done = 0;
        RST = 1'b1;
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'b0;
        rd(8'h00, exp_ctrl(2'h0, 6'b011100), "ctrl reset");
        rd(8'h04, 32'h0, "autoreset enables reset");
        rd(8'h08, 32'h0, "attempt limit reset");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        for (int i = 0; i < 5; i++) begin
            v = $random(seed);
            apb(1'b1, 8'h14 + 8'(i * 4), v);
            rd(8'h14 + 8'(i * 4), {16'h0, v[15:0]}, "category delay");
        end
        $display("test registers done");
        // Stop pin kept high in edge mode, where run edges never halt the motor
        pins.set_pins(5'b00100);
        pins.run_edge(1'b0);
        wait_out(O_RUN, 1'b1, 4, "edge start unassigned enable");
        chk("forward direction", {31'h0, outs[O_DIR]}, 32'h0);
        pins.run_edge(1'b1);
        wait_out(O_DIR, 1'b1, 4, "last edge reverse");
        pins.set_pins(5'b11000);
        wait_out(O_RUN, 1'b0, 6, "stop pin low");
        pins.set_pins(5'b11100);
        repeat (8) @(posedge SYS_CLK);
        chk("held level no start", {31'h0, outs[O_RUN]}, 32'h0);
        apb(1'b1, 8'h00, exp_ctrl(2'h0, 6'b011110));
        pins.run_edge(1'b0);
        wait_out(O_RUN, 1'b0, 2, "enable low blocks");
        wait_out(O_COAST, 1'b1, 2, "enable low coasts");
        pins.set_pins(5'b00110);
        pins.run_edge(1'b0);
        wait_out(O_RUN, 1'b1, 4, "enable high start");
        pins.set_pins(5'b10100);
        wait_out(O_COAST, 1'b1, 6, "enable drop coasts");
        wait_out(O_RUN, 1'b0, 2, "enable drop stops");
        $display("test edge control done");
        pins.set_pins(5'b00110);
        pins.run_edge(1'b0);
        fault(5'h04);
        wait_out(O_LAMP, 1'b1, 4, "trip lamp");
        wait_out(O_PEND, 1'b1, 4, "manual recovery pending");
        chk("trip stops", {31'h0, outs[O_RUN]}, 32'h0);
        pins.run_edge(1'b0);
        chk("no start while tripped", {31'h0, outs[O_RUN]}, 32'h0);
        key_pulse();
        wait_out(O_MSG, 1'b0, 4, "reset clears message");
        wait_out(O_LAMP, 1'b0, 2, "reset clears lamp");
        wait_out(O_PEND, 1'b0, 2, "pending clears");
        repeat (6) @(posedge SYS_CLK);
        chk("no start after reset", {31'h0, outs[O_RUN]}, 32'h0);
        pins.run_edge(1'b0);
        wait_out(O_RUN, 1'b1, 4, "fresh edge starts");
        fault(5'h01);
        pins.reset_edge(1'b0);
        wait_out(O_LAMP, 1'b0, 4, "pin edge reset");
        apb(1'b1, 8'h00, exp_ctrl(2'h0, 6'b100110));
        fault(5'h02);
        key_pulse();
        repeat (8) @(posedge SYS_CLK);
        chk("keypad source off", {31'h0, outs[O_LAMP]}, 32'h1);
        VIO_RESET <= 1'b1;
        wait_out(O_LAMP, 1'b0, 6, "virtual reset");
        VIO_RESET <= 1'b0;
        $display("test trip and reset done");
        apb(1'b1, 8'h00, exp_ctrl(2'h0, 6'b011111));
        pins.set_pins(5'b10110);
        wait_out(O_RUN, 1'b1, 6, "level start");
        fault(5'h08);
        wait_out(O_RUN, 1'b0, 4, "level trip stops");
        key_pulse();
        wait_out(O_RUN, 1'b1, 4, "held run starts at reset");
        pins.set_pins(5'b11110);
        wait_out(O_RUN, 1'b0, 6, "both runs stop");
        pins.set_pins(5'b01110);
        wait_out(O_DIR, 1'b1, 6, "level reverse");
        pins.set_pins(5'b01100);
        wait_out(O_RUN, 1'b0, 6, "level needs enable");
        WARN_IN <= 1'b1;
        wait_out(O_WARN, 1'b1, 3, "warning shown");
        WARN_IN <= 1'b0;
        wait_out(O_WARN, 1'b0, 3, "warning clears alone");
        chk("warning no trip", {31'h0, outs[O_LAMP]}, 32'h0);
        $display("test level control done");
        apb(1'b1, 8'h00, exp_ctrl(2'h0, 6'b011100));
        apb(1'b1, 8'h04, 32'h1f);
        apb(1'b1, 8'h08, 32'h6);
        for (int i = 0; i < 5; i++) apb(1'b1, 8'h14 + 8'(i * 4), 32'(i % 2 + 1));
        pins.set_pins(5'b00100);
        pins.reset_edge(1'b1);
        for (int c = 0; c < 5; c++) begin
            fault(5'(1 << c));
            wait_out(O_LAMP, 1'b1, 4, "category trip");
            wait_out(O_LAMP, 1'b0, 80, "category autoreset");
        end
        apb(1'b0, 8'h10, 32'h0);
        chk("attempt count", {28'h0, rdata[14:11]}, 32'h5);
        chk("not exhausted", {31'h0, outs[O_EXH]}, 32'h0);
        fault(5'h01);
        wait_out(O_EXH, 1'b1, 80, "retry exhausted");
        fault(5'h01);
        repeat (80) @(posedge SYS_CLK);
        chk("stays tripped at limit", {31'h0, outs[O_LAMP]}, 32'h1);
        wait_out(O_PEND, 1'b1, 2, "pending at limit");
        pins.set_pins(5'b00100);
        key_pulse();
        wait_out(O_EXH, 1'b0, 4, "manual reset clears count");
        fault(5'h01);
        repeat (80) @(posedge SYS_CLK);
        chk("no autoreset pin low", {31'h0, outs[O_LAMP]}, 32'h1);
        key_pulse();
        apb(1'b1, 8'h00, exp_ctrl(2'h1, 6'b011100));
        pins.reset_edge(1'b1);
        fault(5'h10);
        repeat (80) @(posedge SYS_CLK);
        chk("no autoreset keypad control", {31'h0, outs[O_LAMP]}, 32'h1);
        key_pulse();
        apb(1'b1, 8'h00, exp_ctrl(2'h0, 6'b011100));
        apb(1'b1, 8'h04, 32'h1e);
        fault(5'h01);
        repeat (80) @(posedge SYS_CLK);
        chk("category disabled", {31'h0, outs[O_LAMP]}, 32'h1);
        apb(1'b1, 8'h00, exp_ctrl(2'h2, 6'b000100));
        apb(1'b1, 8'h0c, 32'h4);
        wait_out(O_LAMP, 1'b0, 4, "bus reset");
        apb(1'b1, 8'h0c, 32'h2);
        wait_out(O_RUN, 1'b1, 4, "bus run after reset");
        apb(1'b1, 8'h0c, 32'h3);
        wait_out(O_RUN, 1'b0, 4, "bus both runs stop");
        $display("test autoreset done");
        final_report();
    end
endmodule
`default_nettype wire
